// ### core/msi_pkg.sv
`default_nettype none
package msi_pkg;
	// Register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
	localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;
	// Control register fields
	localparam int CTRL_ERR_CLR_BIT = 0;
	localparam int CTRL_CMD_DONE_BIT = 1;
	localparam int CTRL_CMD_FAIL_BIT = 2;
	// Interrupt event bits
	localparam int IRQ_ESTOP_BIT = 0;
	localparam int IRQ_AMP_BIT = 1;
	localparam int IRQ_OT_BIT = 2;
	localparam int IRQ_CMD_BIT = 3;
	localparam int IRQ_W = 4;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
	localparam int AXES = 2;
	localparam int SW_STANDALONE = 1;
	localparam int SW_W = 4;
endpackage : msi_pkg
`default_nettype wire

// ### core/msi_indicators.sv
`default_nettype none
module msi_indicators (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [msi_pkg::SW_W-1:0] CONFIG_SWITCH,
	input wire logic SYSTEM_FAULT,
	input wire logic BACKUP_BUSY,
	input wire logic [msi_pkg::AXES-1:0] AXIS_PULSING,
	input wire logic [msi_pkg::AXES-1:0] AXIS_DWELL,
	input wire logic [msi_pkg::AXES-1:0] AXIS_STANDBY,
	input wire logic [msi_pkg::AXES-1:0] AXIS_MANUAL,
	input wire logic [msi_pkg::AXES-1:0] JOG_FORWARD_REQUEST,
	input wire logic [msi_pkg::AXES-1:0] JOG_REVERSE_REQUEST,
	input wire logic [msi_pkg::AXES-1:0] FWD_OVERTRAVEL_OK,
	input wire logic [msi_pkg::AXES-1:0] REV_OVERTRAVEL_OK,
	input wire logic [msi_pkg::AXES-1:0] ESTOP_INPUT,
	input wire logic [msi_pkg::AXES-1:0] AMPLIFIER_OK_INPUT,
	input wire logic [msi_pkg::AXES-1:0] CMD_DONE,
	input wire logic [msi_pkg::AXES-1:0] CMD_FAIL,
	input wire logic ERROR_CLEAR,
	output logic [msi_pkg::AXES-1:0] MOTION_ENABLE,
	output logic SUPPLY_PRESENT_INDICATOR,
	output logic MODULE_HEALTHY_INDICATOR,
	output logic SOFTWARE_HEALTHY_INDICATOR,
	output logic BACKUP_WRITE_INDICATOR,
	output logic RUNNING_INDICATOR,
	output logic IDLE_AXIS_INDICATOR,
	output logic HAND_OPERATION_INDICATOR,
	output logic JOG_INDICATOR,
	output logic COMMAND_FAULT_INDICATOR,
	output logic OVERTRAVEL_INDICATOR,
	output logic EMERGENCY_HALT_INDICATOR,
	output logic AMPLIFIER_FAULT_INDICATOR,
	output logic STANDALONE_INDICATOR,
	output logic IRQ
);
	logic [msi_pkg::AXES-1:0] estop_latch;
	logic [msi_pkg::AXES-1:0] amp_latch;
	logic [msi_pkg::AXES-1:0] ot_latch;
	logic [msi_pkg::AXES-1:0] cmd_err;
	logic [msi_pkg::AXES-1:0] ot_open;
	logic [msi_pkg::AXES-1:0] jog_any;
	logic [msi_pkg::IRQ_W-1:0] irq_stat;
	logic [msi_pkg::IRQ_W-1:0] irq_mask;
	logic [msi_pkg::IRQ_W-1:0] irq_event;
	logic [msi_pkg::IRQ_W-1:0] w1c;
	logic [msi_pkg::AXES-1:0] sw_done;
	logic [msi_pkg::AXES-1:0] sw_fail;
	logic standalone;
	logic clear_req;
	logic sw_clear;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic any_fault;

	function automatic logic reg_hit(input logic [11:0] a);
		reg_hit = (a == msi_pkg::CTRL_OFS) || (a == msi_pkg::STAT_OFS) ||
			(a == msi_pkg::IRQ_STAT_OFS) || (a == msi_pkg::IRQ_MASK_OFS);
	endfunction : reg_hit

	// Zero-wait-state slave; unmapped addresses answer with an error
	assign addr_ok = reg_hit(PADDR);
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_ok;
	assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
	assign rd_en = PSEL && !PENABLE && !PWRITE;

	// Software clear and command results arrive as one-cycle write pulses
	assign sw_clear = wr_en && (PADDR == msi_pkg::CTRL_OFS) &&
		PWDATA[msi_pkg::CTRL_ERR_CLR_BIT];
	assign clear_req = ERROR_CLEAR || sw_clear;
	assign w1c = (wr_en && PADDR == msi_pkg::IRQ_STAT_OFS) ?
		PWDATA[msi_pkg::IRQ_W-1:0] : '0;

	generate
		for (genvar i = 0; i < msi_pkg::AXES; i++) begin : g_axis
			assign sw_done[i] = wr_en && (PADDR == msi_pkg::CTRL_OFS) &&
				PWDATA[msi_pkg::CTRL_CMD_DONE_BIT + 8*i];
			assign sw_fail[i] = wr_en && (PADDR == msi_pkg::CTRL_OFS) &&
				PWDATA[msi_pkg::CTRL_CMD_FAIL_BIT + 8*i];
			assign ot_open[i] = !FWD_OVERTRAVEL_OK[i] ||
				!REV_OVERTRAVEL_OK[i];
			assign jog_any[i] = JOG_FORWARD_REQUEST[i] ||
				JOG_REVERSE_REQUEST[i];

			// Halt latch set while stop is off, freed only by a clear
			always_ff @(posedge CLK) begin
				if (RST) begin
					estop_latch[i] <= 1'b0;
				end else if (!ESTOP_INPUT[i]) begin
					estop_latch[i] <= 1'b1;
				end else if (clear_req) begin
					estop_latch[i] <= 1'b0;
				end
			end

			always_ff @(posedge CLK) begin
				if (RST) begin
					amp_latch[i] <= 1'b0;
				end else if (!AMPLIFIER_OK_INPUT[i]) begin
					amp_latch[i] <= 1'b1;
				end else if (clear_req) begin
					amp_latch[i] <= 1'b0;
				end
			end

			// Overtravel fault survives the lamp going dark
			always_ff @(posedge CLK) begin
				if (RST) begin
					ot_latch[i] <= 1'b0;
				end else if (ot_open[i]) begin
					ot_latch[i] <= 1'b1;
				end else if (clear_req) begin
					ot_latch[i] <= 1'b0;
				end
			end

			// A new failure wins over a simultaneous success or clear
			always_ff @(posedge CLK) begin
				if (RST) begin
					cmd_err[i] <= 1'b0;
				end else if (CMD_FAIL[i] || sw_fail[i]) begin
					cmd_err[i] <= 1'b1;
				end else if (CMD_DONE[i] || sw_done[i] || clear_req) begin
					cmd_err[i] <= 1'b0;
				end
			end

			assign MOTION_ENABLE[i] = !estop_latch[i] && !amp_latch[i] &&
				!ot_latch[i];
		end
	endgenerate

	// Strap sampled by a clocked process, never by the reset itself
	always_ff @(posedge CLK) begin
		if (RST) begin
			standalone <= 1'b0;
		end else begin
			standalone <= CONFIG_SWITCH[msi_pkg::SW_STANDALONE];
		end
	end

	assign any_fault = SYSTEM_FAULT || (|estop_latch) || (|amp_latch) ||
		(|ot_latch) || (|cmd_err);

	always_ff @(posedge CLK) begin
		if (RST) begin
			SUPPLY_PRESENT_INDICATOR <= 1'b0;
			MODULE_HEALTHY_INDICATOR <= 1'b0;
			SOFTWARE_HEALTHY_INDICATOR <= 1'b0;
			BACKUP_WRITE_INDICATOR <= 1'b0;
			RUNNING_INDICATOR <= 1'b0;
			IDLE_AXIS_INDICATOR <= 1'b0;
			HAND_OPERATION_INDICATOR <= 1'b0;
			JOG_INDICATOR <= 1'b0;
			COMMAND_FAULT_INDICATOR <= 1'b0;
			OVERTRAVEL_INDICATOR <= 1'b0;
			EMERGENCY_HALT_INDICATOR <= 1'b0;
			AMPLIFIER_FAULT_INDICATOR <= 1'b0;
			STANDALONE_INDICATOR <= 1'b0;
		end else begin
			SUPPLY_PRESENT_INDICATOR <= 1'b1;
			MODULE_HEALTHY_INDICATOR <= !any_fault;
			SOFTWARE_HEALTHY_INDICATOR <= !(SYSTEM_FAULT ||
				(|cmd_err) || (|estop_latch) || (|amp_latch));
			BACKUP_WRITE_INDICATOR <= BACKUP_BUSY;
			RUNNING_INDICATOR <= |(AXIS_PULSING & ~AXIS_DWELL);
			IDLE_AXIS_INDICATOR <= |AXIS_STANDBY;
			HAND_OPERATION_INDICATOR <= |AXIS_MANUAL;
			JOG_INDICATOR <= |jog_any;
			COMMAND_FAULT_INDICATOR <= |cmd_err;
			OVERTRAVEL_INDICATOR <= |ot_open;
			EMERGENCY_HALT_INDICATOR <= |(~ESTOP_INPUT);
			AMPLIFIER_FAULT_INDICATOR <= |(~AMPLIFIER_OK_INPUT);
			STANDALONE_INDICATOR <= standalone;
		end
	end

	assign irq_event = {|(CMD_FAIL | sw_fail), |ot_open,
		|(~AMPLIFIER_OK_INPUT), |(~ESTOP_INPUT)};

	// Set beats write-one-to-clear in the same cycle
	always_ff @(posedge CLK) begin
		if (RST) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~w1c) | irq_event;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			irq_mask <= msi_pkg::IRQ_MASK_RST;
		end else if (wr_en && PADDR == msi_pkg::IRQ_MASK_OFS) begin
			irq_mask <= PWDATA[msi_pkg::IRQ_W-1:0];
		end
	end

	assign IRQ = |(irq_stat & irq_mask);

	// Read data captured in setup so it is stable through the access phase
	always_ff @(posedge CLK) begin
		if (RST) begin
			PRDATA <= '0;
		end else if (rd_en) begin
			unique case (PADDR)
				msi_pkg::STAT_OFS: PRDATA <= {16'h0000,
					6'h00, standalone, |ot_latch, cmd_err, amp_latch,
					estop_latch, MOTION_ENABLE};
				msi_pkg::IRQ_STAT_OFS: PRDATA <= {28'h0000000, irq_stat};
				msi_pkg::IRQ_MASK_OFS: PRDATA <= {28'h0000000, irq_mask};
				default: PRDATA <= '0;
			endcase
		end
	end

	// Halt checks watch axis A and amplifier checks axis B; the other
	// axis is the same generate copy, so one of each is enough
	estop_hold_a: assert property (@(posedge CLK)
		disable iff (RST) estop_latch[0] && ESTOP_INPUT[0] &&
		!clear_req |=> estop_latch[0])
		else $error("halt latch released without clear");
	halt_release_a: assert property (@(posedge CLK)
		disable iff (RST) clear_req && ESTOP_INPUT[0]
		|=> !estop_latch[0])
		else $error("halt latch kept after clear");
	estop_set_a: assert property (@(posedge CLK)
		disable iff (RST) !ESTOP_INPUT[0]
		|=> !MOTION_ENABLE[0] && EMERGENCY_HALT_INDICATOR)
		else $error("motion allowed during stop");
	halt_lamp_off_a: assert property (@(posedge CLK)
		disable iff (RST) (&ESTOP_INPUT)
		|=> !EMERGENCY_HALT_INDICATOR)
		else $error("halt lamp lit with stop input on");
	amp_block_a: assert property (@(posedge CLK)
		disable iff (RST) !AMPLIFIER_OK_INPUT[1] |=> !MOTION_ENABLE[1]
		##1 (!MOTION_ENABLE[1] || $past(clear_req)))
		else $error("motion allowed after amp fault");
	amp_hold_a: assert property (@(posedge CLK)
		disable iff (RST) amp_latch[1] && !clear_req
		|=> !MOTION_ENABLE[1])
		else $error("amp latch released without clear");
	amp_lamp_a: assert property (@(posedge CLK)
		disable iff (RST) $rose(AMPLIFIER_OK_INPUT[1]) &&
		AMPLIFIER_OK_INPUT[0] |=> !AMPLIFIER_FAULT_INDICATOR)
		else $error("amp lamp stuck");
	amp_fault_lamp_a: assert property (@(posedge CLK)
		disable iff (RST) !AMPLIFIER_OK_INPUT[1]
		|=> AMPLIFIER_FAULT_INDICATOR)
		else $error("amp lamp dark with amplifier not ready");
	run_dwell_a: assert property (@(posedge CLK)
		disable iff (RST) AXIS_DWELL[1] &&
		!(AXIS_PULSING[0] && !AXIS_DWELL[0]) |=> !RUNNING_INDICATOR)
		else $error("running lamp lit during dwell");
	run_lamp_a: assert property (@(posedge CLK)
		disable iff (RST) AXIS_PULSING[1] && !AXIS_DWELL[1]
		|=> RUNNING_INDICATOR)
		else $error("running lamp dark while pulsing");
	run_idle_a: assert property (@(posedge CLK)
		disable iff (RST) !(|AXIS_PULSING)
		|=> !RUNNING_INDICATOR)
		else $error("running lamp lit with no pulses");
	jog_lamp_a: assert property (@(posedge CLK)
		disable iff (RST) JOG_REVERSE_REQUEST[0]
		|=> JOG_INDICATOR)
		else $error("jog lamp dark");
	jog_fwd_a: assert property (@(posedge CLK)
		disable iff (RST) JOG_FORWARD_REQUEST[1]
		|=> JOG_INDICATOR)
		else $error("jog lamp dark on forward request");
	jog_off_a: assert property (@(posedge CLK)
		disable iff (RST) !(|JOG_FORWARD_REQUEST) &&
		!(|JOG_REVERSE_REQUEST) |=> !JOG_INDICATOR)
		else $error("jog lamp lit with no request");
	ot_lamp_a: assert property (@(posedge CLK)
		disable iff (RST) (&FWD_OVERTRAVEL_OK) && (&REV_OVERTRAVEL_OK)
		|=> !OVERTRAVEL_INDICATOR)
		else $error("overtravel lamp stuck");
	ot_on_a: assert property (@(posedge CLK)
		disable iff (RST) !FWD_OVERTRAVEL_OK[0] ||
		!REV_OVERTRAVEL_OK[1] |=> OVERTRAVEL_INDICATOR)
		else $error("overtravel lamp dark with input off");
	ot_hold_a: assert property (@(posedge CLK)
		disable iff (RST) ot_latch[0] && !clear_req
		|=> ot_latch[0])
		else $error("overtravel fault forgotten without clear");
	cmd_clear_a: assert property (@(posedge CLK)
		disable iff (RST) ERROR_CLEAR && !(|CMD_FAIL) && !(|sw_fail)
		|=> ##1 !COMMAND_FAULT_INDICATOR)
		else $error("cmd fault not cleared");
	cmd_done_a: assert property (@(posedge CLK)
		disable iff (RST) CMD_DONE[0] && !CMD_FAIL[0] && !sw_fail[0]
		|=> !cmd_err[0])
		else $error("cmd fault kept after good command");
	cmd_fail_a: assert property (@(posedge CLK)
		disable iff (RST) CMD_FAIL[1]
		|=> ##1 COMMAND_FAULT_INDICATOR)
		else $error("cmd fault lamp dark after failure");
	healthy_lamp_a: assert property (@(posedge CLK)
		disable iff (RST) any_fault
		|=> !MODULE_HEALTHY_INDICATOR)
		else $error("healthy lamp lit with fault");
	sw_healthy_a: assert property (@(posedge CLK)
		disable iff (RST) SYSTEM_FAULT
		|=> !SOFTWARE_HEALTHY_INDICATOR)
		else $error("software lamp lit with system fault");
	backup_lamp_a: assert property (@(posedge CLK)
		disable iff (RST) BACKUP_BUSY
		|=> BACKUP_WRITE_INDICATOR)
		else $error("backup lamp dark while storing");
	backup_off_a: assert property (@(posedge CLK)
		disable iff (RST) !BACKUP_BUSY
		|=> !BACKUP_WRITE_INDICATOR)
		else $error("backup lamp lit after storing");
	idle_lamp_a: assert property (@(posedge CLK)
		disable iff (RST) AXIS_STANDBY[0]
		|=> IDLE_AXIS_INDICATOR)
		else $error("idle lamp dark while standing by");
	hand_off_a: assert property (@(posedge CLK)
		disable iff (RST) !(|AXIS_MANUAL)
		|=> !HAND_OPERATION_INDICATOR)
		else $error("hand lamp lit after manual cancelled");
	standalone_lamp_a: assert property (@(posedge CLK)
		disable iff (RST) CONFIG_SWITCH[msi_pkg::SW_STANDALONE] ##1
		CONFIG_SWITCH[msi_pkg::SW_STANDALONE] |=> STANDALONE_INDICATOR)
		else $error("standalone lamp dark");
endmodule : msi_indicators
`default_nettype wire

// ### verification/msi_lamp_panel.sv
`default_nettype none
module msi_lamp_panel (
	input wire logic clk,
	input wire logic [12:0] lamps,
	output logic [12:0] seen
);
	timeunit 1ns;
	timeprecision 100ps;
	// Operator view lags the lamp drivers by one clock; a lamp keeps no memory
	always_ff @(posedge clk) begin
		seen <= lamps;
	end
endmodule : msi_lamp_panel
`default_nettype wire

// ### verification/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, er;
	logic SYSTEM_FAULT, BACKUP_BUSY, ERROR_CLEAR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [3:0] CONFIG_SWITCH;
	logic [1:0] AXIS_PULSING, AXIS_DWELL, AXIS_STANDBY, AXIS_MANUAL;
	logic [1:0] JOG_FORWARD_REQUEST, JOG_REVERSE_REQUEST, CMD_DONE, CMD_FAIL;
	logic [1:0] FWD_OVERTRAVEL_OK, REV_OVERTRAVEL_OK, ESTOP_INPUT;
	logic [1:0] AMPLIFIER_OK_INPUT, MOTION_ENABLE;
	logic SUPPLY_PRESENT_INDICATOR, MODULE_HEALTHY_INDICATOR;
	logic SOFTWARE_HEALTHY_INDICATOR, BACKUP_WRITE_INDICATOR;
	logic RUNNING_INDICATOR, IDLE_AXIS_INDICATOR, HAND_OPERATION_INDICATOR;
	logic JOG_INDICATOR, COMMAND_FAULT_INDICATOR, OVERTRAVEL_INDICATOR;
	logic EMERGENCY_HALT_INDICATOR, AMPLIFIER_FAULT_INDICATOR;
	logic STANDALONE_INDICATOR;
	logic [12:0] seen;
	int miscompares, num_checks, cyc;
	msi_indicators msi_indicators_i (.*);
	msi_lamp_panel msi_lamp_panel_i (.clk(CLK), .seen(seen),
		.lamps({SUPPLY_PRESENT_INDICATOR, MODULE_HEALTHY_INDICATOR,
		SOFTWARE_HEALTHY_INDICATOR, BACKUP_WRITE_INDICATOR, RUNNING_INDICATOR,
		IDLE_AXIS_INDICATOR, HAND_OPERATION_INDICATOR, JOG_INDICATOR,
		COMMAND_FAULT_INDICATOR, OVERTRAVEL_INDICATOR, EMERGENCY_HALT_INDICATOR,
		AMPLIFIER_FAULT_INDICATOR, STANDALONE_INDICATOR}));
	initial begin
		CLK = 0;
		forever #2.5 CLK = ~CLK;
	end
	task wrap_up;
		if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk
	// Two edges: one for a latch, one for the lamp register that follows it
	task w;
		repeat (2) @(posedge CLK);
		#1;
	endtask : w
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK) begin
			PSEL <= 1; PWRITE <= wr; PADDR <= a; PWDATA <= d;
		end
		@(posedge CLK) PENABLE <= 1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 0;
		PENABLE <= 0;
	endtask : apb
	task ec;
		@(posedge CLK) ERROR_CLEAR <= 1;
		@(posedge CLK) ERROR_CLEAR <= 0;
		w;
	endtask : ec
	task t_lamps;
		@(posedge CLK) AXIS_PULSING <= 2'b10;
		w; chk("run", RUNNING_INDICATOR, 1);
		@(posedge CLK) AXIS_DWELL <= 2'b10;
		w; chk("run dwell", RUNNING_INDICATOR, 0);
		@(posedge CLK) begin AXIS_STANDBY <= 2'b01; AXIS_MANUAL <= 2'b10; end
		w; chk("idle", IDLE_AXIS_INDICATOR, 1);
		chk("hand", HAND_OPERATION_INDICATOR, 1);
		@(posedge CLK) begin AXIS_MANUAL <= 0; JOG_REVERSE_REQUEST <= 2'b01; end
		w; chk("hand", HAND_OPERATION_INDICATOR, 0);
		chk("jog", JOG_INDICATOR, 1);
		@(posedge CLK) begin
			JOG_REVERSE_REQUEST <= '0;
			JOG_FORWARD_REQUEST <= 2'b10;
		end
		w; chk("jog", JOG_INDICATOR, 1);
		@(posedge CLK) begin JOG_FORWARD_REQUEST <= 0; BACKUP_BUSY <= 1; end
		w; chk("jog", JOG_INDICATOR, 0);
		chk("backup", BACKUP_WRITE_INDICATOR, 1);
		@(posedge CLK) begin BACKUP_BUSY <= 0; SYSTEM_FAULT <= 1; end
		w; chk("backup", BACKUP_WRITE_INDICATOR, 0);
		chk("sw ok", SOFTWARE_HEALTHY_INDICATOR, 0);
		chk("mod ok", MODULE_HEALTHY_INDICATOR, 0);
		@(posedge CLK) begin SYSTEM_FAULT <= 0; CONFIG_SWITCH <= 4'h2; end
		w; chk("sw ok", SOFTWARE_HEALTHY_INDICATOR, 1);
		chk("alone", STANDALONE_INDICATOR, 1);
		@(posedge CLK) CONFIG_SWITCH <= 4'hD;
		w; chk("alone", STANDALONE_INDICATOR, 0);
	endtask : t_lamps
	task t_trip;
		apb(1, msi_pkg::IRQ_MASK_OFS, 32'h1);
		@(posedge CLK) ESTOP_INPUT <= 2'b10;
		w; chk("halt", EMERGENCY_HALT_INDICATOR, 1);
		chk("enable", MOTION_ENABLE, 2'b10);
		chk("sw ok", SOFTWARE_HEALTHY_INDICATOR, 0);
		chk("irq", IRQ, 1);
		ec; chk("enable", MOTION_ENABLE, 2'b10);
		@(posedge CLK) ESTOP_INPUT <= 2'b11;
		w; chk("halt", EMERGENCY_HALT_INDICATOR, 0);
		chk("enable", MOTION_ENABLE, 2'b10);
		ec; chk("enable", MOTION_ENABLE, 2'b11);
		apb(1, msi_pkg::IRQ_STAT_OFS, 32'h1);
		#1 chk("irq", IRQ, 0);
		@(posedge CLK) AMPLIFIER_OK_INPUT <= 2'b01;
		w; chk("amp", AMPLIFIER_FAULT_INDICATOR, 1);
		chk("enable", MOTION_ENABLE, 2'b01);
		@(posedge CLK) AMPLIFIER_OK_INPUT <= 2'b11;
		w; chk("amp", AMPLIFIER_FAULT_INDICATOR, 0);
		chk("enable", MOTION_ENABLE, 2'b01);
		apb(1, msi_pkg::CTRL_OFS, 32'h1);
		w; chk("enable", MOTION_ENABLE, 2'b11);
		chk("mod ok", MODULE_HEALTHY_INDICATOR, 1);
	endtask : t_trip
	task t_ot;
		@(posedge CLK) begin
			FWD_OVERTRAVEL_OK <= 2'b10;
			REV_OVERTRAVEL_OK <= 2'b01;
		end
		w; chk("ot", OVERTRAVEL_INDICATOR, 1);
		@(posedge CLK) FWD_OVERTRAVEL_OK <= 2'b11;
		w; chk("ot", OVERTRAVEL_INDICATOR, 1);
		@(posedge CLK) REV_OVERTRAVEL_OK <= 2'b11;
		w; chk("ot", OVERTRAVEL_INDICATOR, 0);
		chk("mod ok", MODULE_HEALTHY_INDICATOR, 0);
		ec; chk("mod ok", MODULE_HEALTHY_INDICATOR, 1);
	endtask : t_ot
	task t_cmd;
		@(posedge CLK) CMD_FAIL <= 2'b01;
		@(posedge CLK) CMD_FAIL <= 0;
		w; chk("cmd", COMMAND_FAULT_INDICATOR, 1);
		@(posedge CLK) CMD_DONE <= 2'b01;
		@(posedge CLK) CMD_DONE <= 0;
		w; chk("cmd", COMMAND_FAULT_INDICATOR, 0);
		@(posedge CLK) CMD_FAIL <= 2'b10;
		@(posedge CLK) CMD_FAIL <= 0;
		w; chk("cmd", COMMAND_FAULT_INDICATOR, 1);
		ec; chk("cmd", COMMAND_FAULT_INDICATOR, 0);
		apb(0, 12'h010, 0);
		chk("slverr", er, 1);
		apb(0, msi_pkg::STAT_OFS, 0);
		chk("status", rd, 32'h003);
		apb(1, msi_pkg::CTRL_OFS, 32'h4);
		w; chk("cmd sw", COMMAND_FAULT_INDICATOR, 1);
		apb(1, msi_pkg::CTRL_OFS, 32'h200);
		w; chk("cmd sw", COMMAND_FAULT_INDICATOR, 1);
		apb(1, msi_pkg::CTRL_OFS, 32'h2);
		w; chk("cmd sw", COMMAND_FAULT_INDICATOR, 0);
		apb(0, msi_pkg::IRQ_STAT_OFS, 0);
		chk("irq stat", rd, 32'hE);
		chk("slverr", er, 0);
		apb(0, msi_pkg::IRQ_MASK_OFS, 0);
		chk("irq mask", rd, 32'h1);
	endtask : t_cmd
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up;
		end
	end
	initial begin
		{PSEL, PENABLE, PWRITE, PADDR, PWDATA, SYSTEM_FAULT, BACKUP_BUSY} = 0;
		{ERROR_CLEAR, CONFIG_SWITCH, AXIS_PULSING, AXIS_DWELL} = 0;
		{AXIS_STANDBY, AXIS_MANUAL, JOG_FORWARD_REQUEST, JOG_REVERSE_REQUEST} = 0;
		{CMD_DONE, CMD_FAIL} = 0;
		{FWD_OVERTRAVEL_OK, REV_OVERTRAVEL_OK, ESTOP_INPUT} = 6'h3F;
		AMPLIFIER_OK_INPUT = 2'b11;
		RST = 1;
		repeat (4) @(posedge CLK);
		RST <= 0;
		w; chk("supply", seen[12], 1);
		chk("mod ok", MODULE_HEALTHY_INDICATOR, 1);
		t_lamps;
		t_trip;
		t_ot;
		t_cmd;
		wrap_up;
	end
endmodule : tb
`default_nettype wire
